// file: flwb_cmd.sv
// Overview of operation
// R1: set-latch command sets write enable latch
// R2: set-latch only when select rises after bit 8
// R3: boot write needs latch set first
// R4: clear-latch command clears write enable latch
// R5: clear-latch ignored while write in progress
// R6: clear-latch only when select rises after bit 8
// R7: clear-status resets erase and program fail flags
// R8: clear-status needs no latch, works while busy
// R9: clear-status leaves write enable latch alone
// R10: boot read starts at stored address after reset
// R11: boot output waits start-delay clock cycles
// R12: host limits boot clock by delay value
// R13: boot address 512-byte aligned, default zero
// R14: boot streams until select rises after byte
// R15: boot mode not re-entered until next reset
// R16: boot register holds address, delay, enable
// R17: quad bit selects four-bit boot output
// R18: boot register read: low byte first, msb first
// R19: boot register read repeats every 32 clocks
// R20: boot write takes 32 bits, low byte first
// R21: boot write runs only after exactly 32 bits
// R22: update holds write-in-progress, then clears latch
// R23: update failures set erase or program fail
// R24: host polls write-in-progress before next write
`include "flwb_params.svh"
`default_nettype none
module flwb_cmd import flwb_pkg::*; #(
    parameter int unsigned ERASE_CYC = `FLWB_ERASE_CYC,
    parameter int unsigned PROG_CYC = `FLWB_PROG_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_reset,
    // serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out_r,
    output logic [3:0] io_oe_n_r,
    // neighbouring device logic
    input wire logic [7:0] cfg_reg_one,
    input wire logic embedded_busy,
    input wire logic erase_fault,
    input wire logic program_fault,
    // array read port for boot stream
    output logic [31:0] boot_rd_addr_r,
    input wire logic [7:0] boot_rd_data,
    // status flags
    output logic write_enable_latch_r,
    output logic write_in_progress_r,
    output logic erase_fail_r,
    output logic program_fail_r,
    output logic boot_active_r
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [2:0] cs_sync_r;
    logic [2:0] sck_sync_r;
    logic [3:0] io_s1_r;
    logic [3:0] io_s2_r;
    logic cs_fall, cs_rise, sck_rise, sck_fall, si;
    flwb_state_t state_r;
    logic [5:0] bit_cnt_r;
    logic [31:0] shift_r;
    logic [7:0] opcode_r;
    logic [7:0] opcode_nxt;
    logic [4:0] out_cnt_r;
    logic read_boot_r;
    logic exec_set, exec_clr, exec_clrs, exec_wr;
    logic boot_armed_r, arm_pend_r, boot_byte_done_r;
    logic [7:0] boot_byte_r;
    logic [7:0] boot_delay_r;
    logic [2:0] boot_phase_r;
    logic quad;
    logic [7:0] status_byte;
    logic [31:0] wr_word;
    flwb_boot_cfg_t cfg;
    logic nv_busy, nv_done, nv_efail, nv_pfail;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_sync_r <= 3'h7;
            sck_sync_r <= 3'h0;
            io_s1_r <= 4'h0;
            io_s2_r <= 4'h0;
        end else begin
            cs_sync_r <= {cs_sync_r[1:0], cs_n};
            sck_sync_r <= {sck_sync_r[1:0], sck};
            io_s1_r <= io_in;
            io_s2_r <= io_s1_r;
        end
    end

    assign cs_fall = cs_sync_r[2] & ~cs_sync_r[1];
    assign cs_rise = ~cs_sync_r[2] & cs_sync_r[1];
    assign sck_rise = ~sck_sync_r[2] & sck_sync_r[1] & ~cs_sync_r[1];
    assign sck_fall = sck_sync_r[2] & ~sck_sync_r[1] & ~cs_sync_r[1];
    assign si = io_s2_r[0];
    assign opcode_nxt = {shift_r[6:0], si};
    assign quad = cfg_reg_one[`FLWB_CR1_QUAD];

    // status register one image
    always_comb begin
        status_byte = 8'h00;
        status_byte[`FLWB_SR1_WIP] = write_in_progress_r;
        status_byte[`FLWB_SR1_WEL] = write_enable_latch_r;
        status_byte[`FLWB_SR1_EFAIL] = erase_fail_r;
        status_byte[`FLWB_SR1_PFAIL] = program_fail_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // command state machine
    always_ff @(posedge clk) begin
        if (sys_rst || cmd_reset) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state_r <= boot_armed_r ? ST_BOOT : ST_OPCODE; // see R10
                    end
                end
                ST_OPCODE: begin
                    if (cs_rise) begin
                        state_r <= ST_IDLE;
                    end else if (sck_rise && bit_cnt_r == `FLWB_OPCODE_BITS - 6'h01) begin
                        case (opcode_nxt)
                            `FLWB_OP_BOOT_RD: state_r <= ST_RDOUT;
                            `FLWB_OP_STATUS_RD: state_r <= ST_RDOUT; // see R22
                            `FLWB_OP_BOOT_WR: state_r <= ST_WDATA;
                            default: state_r <= ST_SKIP;
                        endcase
                    end
                end
                ST_WDATA, ST_RDOUT, ST_SKIP, ST_BOOT: begin
                    if (cs_rise) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // serial input shifting and frame bit count
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bit_cnt_r <= 6'h00;
            shift_r <= 32'h00000000;
            opcode_r <= 8'h00;
            read_boot_r <= 1'b0;
        end else if (cs_fall) begin
            bit_cnt_r <= 6'h00;
        end else if (sck_rise && state_r != ST_BOOT) begin
            shift_r <= {shift_r[30:0], si};
            if (bit_cnt_r != 6'h3f) begin
                bit_cnt_r <= bit_cnt_r + 6'h01;
            end
            if (bit_cnt_r == `FLWB_OPCODE_BITS - 6'h01) begin
                opcode_r <= opcode_nxt;
                read_boot_r <= (opcode_nxt == `FLWB_OP_BOOT_RD);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command execution at select rising
    assign exec_set = cs_rise && state_r == ST_SKIP && opcode_r == `FLWB_OP_SET_LATCH
        && bit_cnt_r == `FLWB_OPCODE_BITS; // see R1, R2
    assign exec_clr = cs_rise && state_r == ST_SKIP && opcode_r == `FLWB_OP_CLR_LATCH
        && bit_cnt_r == `FLWB_OPCODE_BITS && !write_in_progress_r; // see R4, R5, R6
    assign exec_clrs = cs_rise && state_r == ST_SKIP && opcode_r == `FLWB_OP_CLR_STATUS
        && bit_cnt_r == `FLWB_OPCODE_BITS; // see R7, R8
    assign exec_wr = cs_rise && state_r == ST_WDATA && bit_cnt_r == `FLWB_BOOT_WR_BITS
        && write_enable_latch_r && !write_in_progress_r && !nv_busy; // see R3, R21
    // bytes arrive low byte first
    assign wr_word = {shift_r[7:0], shift_r[15:8], shift_r[23:16], shift_r[31:24]}; // see R20

    // write enable latch, set wins over completion clear
    always_ff @(posedge clk) begin
        if (sys_rst || cmd_reset) begin
            write_enable_latch_r <= 1'b0;
        end else if (exec_set) begin
            write_enable_latch_r <= 1'b1; // see R1
        end else if (exec_clr || nv_done) begin
            write_enable_latch_r <= 1'b0; // see R4, R22
        end
    end

    // busy flag tracks the update and other embedded work
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            write_in_progress_r <= 1'b0;
        end else begin
            write_in_progress_r <= nv_busy | exec_wr | embedded_busy; // see R22
        end
    end

    // fail flags, hardware set wins over clear-status; latch untouched here
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            erase_fail_r <= 1'b0;
            program_fail_r <= 1'b0;
        end else begin
            if (nv_efail) begin
                erase_fail_r <= 1'b1; // see R23
            end else if (exec_clrs) begin
                erase_fail_r <= 1'b0; // see R7, R9
            end
            if (nv_pfail) begin
                program_fail_r <= 1'b1; // see R23
            end else if (exec_clrs) begin
                program_fail_r <= 1'b0; // see R7, R9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // boot arming, caught one cycle after any reset
    always_ff @(posedge clk) begin
        if (sys_rst || cmd_reset) begin
            arm_pend_r <= 1'b1;
            boot_armed_r <= 1'b0;
        end else if (arm_pend_r) begin
            arm_pend_r <= 1'b0;
            boot_armed_r <= cfg.enable; // see R10
        end else if (cs_rise && state_r == ST_BOOT && boot_byte_done_r) begin
            boot_armed_r <= 1'b0; // see R14, R15
        end
    end

    // boot stream address, byte, delay and phase
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boot_rd_addr_r <= 32'h00000000;
            boot_byte_r <= 8'h00;
            boot_delay_r <= 8'h00;
            boot_phase_r <= 3'h0;
            boot_byte_done_r <= 1'b0;
        end else if (arm_pend_r || (cs_rise && state_r == ST_BOOT && !boot_byte_done_r)) begin
            boot_rd_addr_r <= {cfg.start_address, `FLWB_BOOT_ALIGN_BITS'(0)}; // see R13
            boot_byte_done_r <= 1'b0;
        end else if (cs_fall && boot_armed_r) begin
            boot_byte_r <= boot_rd_data;
            boot_rd_addr_r <= boot_rd_addr_r + 32'h00000001;
            boot_delay_r <= cfg.start_delay; // see R11
            boot_phase_r <= 3'h0;
        end else if (sck_fall && state_r == ST_BOOT) begin
            if (boot_delay_r != 8'h00) begin
                boot_delay_r <= boot_delay_r - 8'h01; // see R11
            end else if (boot_phase_r == (quad ? 3'h1 : 3'h7)) begin
                boot_byte_r <= boot_rd_data; // see R14
                boot_rd_addr_r <= boot_rd_addr_r + 32'h00000001;
                boot_phase_r <= 3'h0;
                boot_byte_done_r <= 1'b1;
            end else begin
                boot_phase_r <= boot_phase_r + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pins and read-out counter
    always_ff @(posedge clk) begin
        if (sys_rst || cmd_reset) begin
            io_out_r <= 4'h0;
            io_oe_n_r <= 4'hf;
            out_cnt_r <= 5'h00;
            boot_active_r <= 1'b0;
        end else if (cs_rise || state_r == ST_IDLE) begin
            io_oe_n_r <= 4'hf;
            out_cnt_r <= 5'h00;
            boot_active_r <= 1'b0;
            if (cs_fall && boot_armed_r && cfg.start_delay == 8'h00) begin
                // zero delay: first bits appear with select falling
                boot_active_r <= 1'b1;
                io_oe_n_r <= quad ? 4'h0 : 4'hd; // see R17
                io_out_r <= quad ? boot_rd_data[7:4] : {2'h0, boot_rd_data[7], 1'b0};
            end else if (cs_fall && boot_armed_r) begin
                boot_active_r <= 1'b1;
            end
        end else if (sck_fall && state_r == ST_RDOUT) begin
            out_cnt_r <= out_cnt_r + 5'h01; // see R19
            io_oe_n_r <= 4'hd;
            if (read_boot_r) begin
                io_out_r <= {2'h0, cfg[{out_cnt_r[4:3], ~out_cnt_r[2:0]}], 1'b0}; // see R18
            end else begin
                io_out_r <= {2'h0, status_byte[~out_cnt_r[2:0]], 1'b0};
            end
        end else if (sck_fall && state_r == ST_BOOT) begin
            if (boot_delay_r == 8'h01 || (boot_delay_r == 8'h00 && boot_phase_r != (quad ? 3'h1 : 3'h7))) begin
                // first bits after the delay, or the next bits of this byte
                io_oe_n_r <= quad ? 4'h0 : 4'hd; // see R17
                if (quad) begin
                    io_out_r <= (boot_delay_r == 8'h01) ? boot_byte_r[7:4] : boot_byte_r[3:0];
                end else if (boot_delay_r == 8'h01) begin
                    io_out_r <= {2'h0, boot_byte_r[7], 1'b0};
                end else begin
                    io_out_r <= {2'h0, boot_byte_r[3'h6 - boot_phase_r], 1'b0};
                end
            end else if (boot_delay_r == 8'h00) begin
                // byte boundary: first bits of the fresh byte
                io_oe_n_r <= quad ? 4'h0 : 4'hd;
                io_out_r <= quad ? boot_rd_data[7:4] : {2'h0, boot_rd_data[7], 1'b0}; // see R14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // non-volatile boot configuration store
    flwb_nv_store #(
        .ERASE_CYC(ERASE_CYC),
        .PROG_CYC(PROG_CYC)
    ) u_nv_store (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(exec_wr),
        .wdata(wr_word),
        .erase_fault(erase_fault),
        .program_fault(program_fault),
        .value_r(cfg),
        .busy_r(nv_busy),
        .done_r(nv_done),
        .erase_fail_r(nv_efail),
        .program_fail_r(nv_pfail)
    );

endmodule
`default_nettype wire

// file: flwb_cmd_monitor.sv
`default_nettype none
module flwb_cmd_monitor import flwb_pkg::*; #(
    parameter int unsigned ERASE_CYC = 2500,
    parameter int unsigned PROG_CYC = 1250
) (
    // clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_reset,
    // inputs from host and neighbours
    input wire logic cs_n,
    input wire logic [7:0] cfg_reg_one,
    input wire logic embedded_busy,
    // observed outputs
    input wire logic [3:0] io_oe_n_r,
    input wire logic write_enable_latch_r,
    input wire logic write_in_progress_r,
    input wire logic erase_fail_r,
    input wire logic program_fail_r,
    input wire logic boot_active_r
);
    logic [15:0] busy_cnt_r;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    // length of the current busy stretch
    always_ff @(posedge clk) begin
        if (sys_rst || cmd_reset || !write_in_progress_r)
            busy_cnt_r <= 16'h0000;
        else
            busy_cnt_r <= busy_cnt_r + 16'h0001;
    end
    ////////////////////////////////////////////////////////////////////////
    AST_RESET_QUIET: assert property (disable iff (1'b0) sys_rst |=> io_oe_n_r == 4'hf
        && !write_enable_latch_r && !write_in_progress_r && !boot_active_r && !erase_fail_r)
        else $error("outputs not cleared by reset");
    AST_OE_IDLE: assert property (cs_n [*6] |-> io_oe_n_r == 4'hf)
        else $error("pins driven while deselected");
    AST_WEL_SET_CS: assert property ($rose(write_enable_latch_r) |-> cs_n)
        else $error("latch set inside a frame");
    AST_WEL_CLR_BUSY: assert property ($fell(write_enable_latch_r) && write_in_progress_r
        |=> !write_in_progress_r)
        else $error("latch cleared while busy without completion");
    AST_WIP_START: assert property ($rose(write_in_progress_r)
        |-> cs_n || embedded_busy || $past(embedded_busy))
        else $error("busy started inside a frame");
    AST_WIP_MAX: assert property (write_in_progress_r |-> busy_cnt_r <= ERASE_CYC + PROG_CYC + 2)
        else $error("update too long");
    AST_WIP_MIN: assert property ($fell(write_in_progress_r) && !$past(cmd_reset)
        |-> busy_cnt_r >= ERASE_CYC)
        else $error("update too short");
    AST_FAIL_SET: assert property ($rose(erase_fail_r) || $rose(program_fail_r)
        |-> $past(write_in_progress_r))
        else $error("fail flag set outside update");
    AST_FAIL_CLR: assert property ($fell(erase_fail_r) || $fell(program_fail_r) |-> cs_n)
        else $error("fail flag cleared inside a frame");
    AST_BOOT_START: assert property ($rose(boot_active_r) |-> !cs_n)
        else $error("boot stream without select");
    AST_BOOT_LANES: assert property (boot_active_r && io_oe_n_r != 4'hf
        |-> io_oe_n_r == (cfg_reg_one[1] ? 4'h0 : 4'hd))
        else $error("boot lanes wrong");
endmodule
bind flwb_cmd flwb_cmd_monitor #(.ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC)) mon (
    .clk(clk), .sys_rst(sys_rst), .cmd_reset(cmd_reset), .cs_n(cs_n), .cfg_reg_one(cfg_reg_one),
    .embedded_busy(embedded_busy), .io_oe_n_r(io_oe_n_r), .write_enable_latch_r(write_enable_latch_r),
    .write_in_progress_r(write_in_progress_r), .erase_fail_r(erase_fail_r),
    .program_fail_r(program_fail_r), .boot_active_r(boot_active_r));
`default_nettype wire

// file: flwb_host_model.sv
`default_nettype none
module flwb_host_model #(
    parameter int HALF = 8
) (
    // clock
    input wire logic clk,
    // device pin drive
    input wire logic [3:0] io_out_r,
    // host driven pins
    output logic cs_n,
    output logic sck,
    output logic [3:0] io_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle pins at time zero
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        io_in = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one frame: n bits out msb first, returned bits sampled just before each rise
    task automatic xfer(input logic [79:0] tx, input int n, input logic quad, output logic [63:0] rx);
        rx = '0;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sck <= 1'b0;
            io_in[0] <= tx[i];
            repeat (HALF) @(posedge clk);
            rx = quad ? {rx[59:0], io_out_r} : {rx[62:0], io_out_r[1]};
            sck <= 1'b1;
            repeat (HALF) @(posedge clk);
        end
        sck <= 1'b0;
        repeat (HALF) @(posedge clk);
        cs_n <= 1'b1;
        io_in <= ~io_in;
        repeat (2 * HALF) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: flwb_nv_store.sv
`include "flwb_params.svh"
`default_nettype none
module flwb_nv_store import flwb_pkg::*; #(
    parameter int unsigned ERASE_CYC = `FLWB_ERASE_CYC,
    parameter int unsigned PROG_CYC = `FLWB_PROG_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // update request
    input wire logic start,
    input wire logic [31:0] wdata,
    input wire logic erase_fault,
    input wire logic program_fault,
    // stored value and progress
    output flwb_boot_cfg_t value_r,
    output logic busy_r,
    output logic done_r,
    output logic erase_fail_r,
    output logic program_fail_r
);

    flwb_nv_phase_t phase_r;
    logic [15:0] cnt_r;
    logic [31:0] pend_r;
    logic last;

    assign last = (phase_r == NV_ERASE) ? (cnt_r == 16'(ERASE_CYC - 1)) : (cnt_r == 16'(PROG_CYC - 1));

    ////////////////////////////////////////////////////////////////////////
    // self-timed erase then program sequence
    always_ff @(posedge clk) begin
        done_r <= 1'b0;
        erase_fail_r <= 1'b0;
        program_fail_r <= 1'b0;
        if (sys_rst) begin
            phase_r <= NV_IDLE;
            cnt_r <= 16'h0000;
            pend_r <= `FLWB_BOOT_RESET;
            busy_r <= 1'b0;
        end else begin
            case (phase_r)
                NV_IDLE: begin
                    if (start) begin
                        phase_r <= NV_ERASE;
                        pend_r <= wdata;
                        cnt_r <= 16'h0000;
                        busy_r <= 1'b1;
                    end
                end
                NV_ERASE: begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (last && erase_fault) begin
                        phase_r <= NV_IDLE; // a failed erase skips programming
                        erase_fail_r <= 1'b1; // see R23
                        done_r <= 1'b1;
                        busy_r <= 1'b0;
                    end else if (last) begin
                        phase_r <= NV_PROG;
                        cnt_r <= 16'h0000;
                    end
                end
                NV_PROG: begin
                    cnt_r <= cnt_r + 16'h0001;
                    if (last) begin
                        phase_r <= NV_IDLE;
                        program_fail_r <= program_fault; // see R23
                        done_r <= 1'b1;
                        busy_r <= 1'b0;
                    end
                end
                default: begin
                    phase_r <= NV_IDLE;
                    busy_r <= 1'b0;
                end
            endcase
        end
    end

    // stored value changes only on a clean program completion
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            value_r <= flwb_boot_cfg_t'(`FLWB_BOOT_RESET); // see R13
        end else if (phase_r == NV_PROG && last && !program_fault) begin
            value_r <= flwb_boot_cfg_t'(pend_r); // see R16
        end
    end

endmodule
`default_nettype wire

// file: flwb_params.svh
`ifndef FLWB_PARAMS_SVH
`define FLWB_PARAMS_SVH

// instruction codes
`define FLWB_OP_SET_LATCH 8'h06
`define FLWB_OP_CLR_LATCH 8'h04
`define FLWB_OP_CLR_STATUS 8'h30
`define FLWB_OP_BOOT_RD 8'h14
`define FLWB_OP_BOOT_WR 8'h15
`define FLWB_OP_STATUS_RD 8'h05

// status register one and configuration register one bit positions
`define FLWB_SR1_WIP 0
`define FLWB_SR1_WEL 1
`define FLWB_SR1_EFAIL 5
`define FLWB_SR1_PFAIL 6
`define FLWB_CR1_QUAD 1

// boot configuration layout and reset value
`define FLWB_BOOT_ABE_BIT 0
`define FLWB_BOOT_BOOT_START_DELAY_LSB 1
`define FLWB_BOOT_BOOT_START_ADDRESS_LSB 9
`define FLWB_BOOT_ALIGN_BITS 9
`define FLWB_BOOT_RESET 32'h00000000

// serial frame bit counts
`define FLWB_OPCODE_BITS 6'h08
`define FLWB_BOOT_WR_BITS 6'h28

// timing
`define FLWB_CLK_MHZ 125
`define FLWB_T_ERASE_US 20
`define FLWB_T_PROG_US 10
`define FLWB_ERASE_CYC (`FLWB_T_ERASE_US * `FLWB_CLK_MHZ)
`define FLWB_PROG_CYC (`FLWB_T_PROG_US * `FLWB_CLK_MHZ)

`endif

// file: flwb_pkg.sv
`default_nettype none
package flwb_pkg;

    // stored boot configuration, msb first
    typedef struct packed {
        logic [22:0] start_address;
        logic [7:0] start_delay;
        logic enable;
    } flwb_boot_cfg_t;

    // command interpreter states, gray along the idle-opcode-write-data path
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_OPCODE = 3'h1,
        ST_WDATA = 3'h3,
        ST_RDOUT = 3'h2,
        ST_BOOT = 3'h6,
        ST_SKIP = 3'h7
    } flwb_state_t;

    // non-volatile update phases
    typedef enum logic [1:0] {
        NV_IDLE = 2'h0,
        NV_ERASE = 2'h1,
        NV_PROG = 2'h3
    } flwb_nv_phase_t;

endpackage
`default_nettype wire

// file: tb_top.sv
`default_nettype none
module tb_top import flwb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned ERASE = 250;
    localparam int unsigned PROG = 250;
    localparam flwb_boot_cfg_t CFG = '{start_address: 23'h000003, start_delay: 8'h02, enable: 1'b1};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_reset = 1'b0;
    logic embedded_busy = 1'b0;
    logic erase_fault = 1'b0;
    logic program_fault = 1'b0;
    logic [7:0] cfg_reg_one = 8'h00;
    logic [7:0] boot_rd_data;
    logic cs_n, sck, write_enable_latch, write_in_progress, efail, pfail, bact;
    logic [3:0] io_in, io_out_r, io_oe_n_r;
    logic [31:0] boot_rd_addr_r, base;
    logic [39:0] wr, wr2;
    logic [63:0] rx;
    int errors = 0;
    int checks = 0;
    ////////////////////////////////////////////////////////////////////////
    // clock and array read port with one clock of latency
    always #4 clk = ~clk;
    always @(posedge clk) boot_rd_data <= boot_rd_addr_r[7:0] ^ 8'h5a;
    flwb_cmd #(.ERASE_CYC(ERASE), .PROG_CYC(PROG)) dut (
        .clk(clk), .sys_rst(sys_rst), .cmd_reset(cmd_reset), .cs_n(cs_n), .sck(sck), .io_in(io_in),
        .io_out_r(io_out_r), .io_oe_n_r(io_oe_n_r), .cfg_reg_one(cfg_reg_one), .embedded_busy(embedded_busy),
        .erase_fault(erase_fault), .program_fault(program_fault), .boot_rd_addr_r(boot_rd_addr_r),
        .boot_rd_data(boot_rd_data), .write_enable_latch_r(write_enable_latch), .write_in_progress_r(write_in_progress),
        .erase_fail_r(efail), .program_fail_r(pfail), .boot_active_r(bact));
    flwb_host_model #(.HALF(8)) host (.clk(clk), .io_out_r(io_out_r), .cs_n(cs_n), .sck(sck), .io_in(io_in));
    ////////////////////////////////////////////////////////////////////////
    // byte order on the wire: low byte first
    function automatic logic [31:0] ser(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic send(input logic [79:0] tx, input int n);
        host.xfer(tx, n, 1'b0, rx);
    endtask
    task automatic pulse_reset;
        cmd_reset <= 1'b1;
        @(posedge clk);
        cmd_reset <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // bounded poll of the busy flag
    task automatic wait_idle;
        for (int i = 0; i < 2000; i++) begin
            @(posedge clk);
            if (write_in_progress === 1'b0)
                return;
        end
        errors++;
        finish_test();
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        wr = {8'h15, ser(CFG)};
        wr2 = {8'h15, ser(~CFG)};
        base = {CFG.start_address, 9'h000};
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        check({write_enable_latch, write_in_progress, efail, pfail, bact}, 5'h00);
        send({8'h14, 32'h0}, 40);
        check(rx[31:0], 32'h00000000);
        send({8'h06, 1'b0}, 9);
        check(write_enable_latch, 1'b0);
        send(8'h06, 8);
        check(write_enable_latch, 1'b1);
        send(8'h04 >> 1, 7);
        check(write_enable_latch, 1'b1);
        send(8'h04, 8);
        check(write_enable_latch, 1'b0);
        send(wr, 40);
        check(write_in_progress, 1'b0);
        send(8'h06, 8);
        send(wr >> 1, 39);
        check({write_in_progress, write_enable_latch}, 2'b01);
        send(wr, 40);
        check(write_in_progress, 1'b1);
        // status read while the update runs: busy and latch both set
        send({8'h05, 8'h00}, 16);
        check(rx[7:0], 8'h03);
        wait_idle();
        check(write_enable_latch, 1'b0);
        send({8'h14, 64'h0}, 72);
        check(rx, {ser(CFG), ser(CFG)});
        // failing erase phase, stored value kept
        erase_fault <= 1'b1;
        send(8'h06, 8);
        send(wr2, 40);
        wait_idle();
        check({efail, pfail, write_enable_latch}, 3'b100);
        erase_fault <= 1'b0;
        // failing program phase with commands issued while busy
        program_fault <= 1'b1;
        send(8'h06, 8);
        send(wr2, 40);
        send(8'h04, 8);
        check({write_in_progress, write_enable_latch}, 2'b11);
        send(8'h30, 8);
        check({write_in_progress, efail}, 2'b10);
        wait_idle();
        check({pfail, write_enable_latch}, 2'b10);
        program_fault <= 1'b0;
        send({8'h14, 32'h0}, 40);
        check(rx[31:0], ser(CFG));
        send(8'h06, 8);
        send(8'h30, 8);
        check({pfail, write_enable_latch}, 2'b01);
        send(8'h04, 8);
        // serial boot stream after command reset, delay then two bytes
        pulse_reset();
        send(80'h0, 2 + 16);
        check(rx[15:0], {base[7:0] ^ 8'h5a, (base[7:0] + 8'h01) ^ 8'h5a});
        send({8'h14, 32'h0}, 40);
        check(rx[31:0], ser(CFG));
        check(boot_rd_addr_r, base + 32'h00000003);
        // four-bit boot stream
        cfg_reg_one <= 8'h02;
        pulse_reset();
        host.xfer(80'h0, 2 + 2, 1'b1, rx);
        check(rx[7:0], base[7:0] ^ 8'h5a);
        cfg_reg_one <= 8'h00;
        // zero start delay: first bit stands as select falls
        send(8'h06, 8);
        send({8'h15, ser(CFG & 32'hfffffe01)}, 40);
        wait_idle();
        pulse_reset();
        send(80'h0, 16);
        check(rx[15:0], {base[7:0] ^ 8'h5a, (base[7:0] + 8'h01) ^ 8'h5a});
        finish_test();
    end
    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
